// file: shared/ppc_pkg.sv
/*
 * ppc_pkg: constants shared by the port pad control block.
 * Holds register indices, per-port pin maps, reset values and field masks.
 * Assumes ports are ordered 1, 2, 3, 4, 5, 8, A, B, C, D, E at indices 0 to 10.
 */
package ppc_pkg;

    localparam int PPC_NPORT = 11;
    localparam int PPC_NPIN  = 8;
    localparam int PPC_NALL  = PPC_NPORT * PPC_NPIN;
    localparam int PPC_NOD   = PPC_NPORT * 4;

    // register indices as printed; byte address is index shifted left by two
    localparam int          PPC_IDX_SHIFT = 2;
    localparam logic [31:0] PPC_OTU_IDX [PPC_NPORT] = '{
        32'h0008c083, 32'h0008c085, 32'h0008c087, 32'h0008c089, 32'h0008c08b, 32'h0008c091,
        32'h0008c095, 32'h0008c097, 32'h0008c099, 32'h0008c09b, 32'h0008c09d};
    localparam logic [31:0] PPC_PUL_IDX [PPC_NPORT] = '{
        32'h0008c0c1, 32'h0008c0c2, 32'h0008c0c3, 32'h0008c0c4, 32'h0008c0c5, 32'h0008c0c8,
        32'h0008c0ca, 32'h0008c0cb, 32'h0008c0cc, 32'h0008c0cd, 32'h0008c0ce};
    localparam logic [31:0] PPC_DRV_IDX [PPC_NPORT] = '{
        32'h0008c0e1, 32'h0008c0e2, 32'h00000000, 32'h00000000, 32'h0008c0e5, 32'h0008c0e8,
        32'h0008c0ea, 32'h0008c0eb, 32'h0008c0ec, 32'h0008c0ed, 32'h0008c0ee};
    localparam logic [31:0] PPC_FST_IDX [PPC_NPORT] = '{
        32'h0008c129, 32'h0008c12a, 32'h0008c12b, 32'h00000000, 32'h0008c12d, 32'h0008c130,
        32'h0008c132, 32'h0008c133, 32'h0008c134, 32'h0008c135, 32'h0008c136};

    // which ports implement the drive registers (bit i is port index i)
    localparam logic [PPC_NPORT-1:0] PPC_DRV_PRESENT = 11'h7f3;
    localparam logic [PPC_NPORT-1:0] PPC_FST_PRESENT = 11'h7f7;

    // pins that exist on each port
    localparam logic [7:0] PPC_PIN_EXISTS [PPC_NPORT] = '{
        8'hcc, 8'hc0, 8'hf3, 8'h0f, 8'h08, 8'h07, 8'h1e, 8'hff, 8'hf3, 8'hfc, 8'hf7};
    // pins whose normal/high drive follows the drive strength bit
    localparam logic [7:0] PPC_DRV_SWITCH [PPC_NPORT] = '{
        8'h0c, 8'h80, 8'h00, 8'h00, 8'h00, 8'h07, 8'h1e, 8'hff, 8'hf3, 8'hfc, 8'hf7};
    // pins that accept the high-speed override
    localparam logic [7:0] PPC_FST_SWITCH [PPC_NPORT] = '{
        8'h8c, 8'h80, 8'h03, 8'h00, 8'h08, 8'h07, 8'h1e, 8'hff, 8'hf3, 8'hfc, 8'hf7};
    // pins whose drive is high without any setting
    localparam logic [7:0] PPC_FIXED_HIGH [PPC_NPORT] = '{
        8'hc0, 8'h40, 8'h93, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // upper output-type field: even bits select pins 4 to 7
    localparam logic [7:0] PPC_OTU_EVEN  = 8'h55;
    localparam logic [7:0] PPC_REG_RESET = 8'h00;
    localparam int         PPC_UPPER_PIN = 4;

    typedef enum logic [2:0] {
        PPC_PH_IDLE   = 3'b001,
        PPC_PH_SETUP  = 3'b010,
        PPC_PH_ACCESS = 3'b100
    } ppc_phase_t;

endpackage

// file: rtl/ppc_port_pad_control.sv
/*
 * ppc_port_pad_control: pad configuration registers for eleven general I/O ports
 * (upper output type, pull-up, drive strength except on ports 3 and 4, high-speed drive
 * override except on port 4) behind an APB slave, and the per-pin pad control outputs derived from them.
 * Assumes direction, pin mode and peripheral output enables come from the port
 * and pin multiplexing logic, synchronous to pclk.
 */
`timescale 1ns/1ps

module ppc_port_pad_control
    import ppc_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                pce,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [PPC_NALL-1:0] direction_select,
    input  wire logic [PPC_NALL-1:0] pin_function_mode,
    input  wire logic [PPC_NALL-1:0] periph_output_en,
    output logic      [PPC_NALL-1:0] pad_output_en,
    output logic      [PPC_NALL-1:0] pull_up_en,
    output logic      [PPC_NOD-1:0]  open_drain_en,
    output logic      [PPC_NALL-1:0] drive_high,
    output logic      [PPC_NALL-1:0] drive_fast
);

    // register storage, one byte per port and kind
    logic [7:0] upper_output_type_select [PPC_NPORT];
    logic [7:0] pull_up_control          [PPC_NPORT];
    logic [7:0] drive_strength_select    [PPC_NPORT];
    logic [7:0] high_speed_drive_override[PPC_NPORT];

    // decode results
    logic [PPC_NPORT-1:0] hit_otu;
    logic [PPC_NPORT-1:0] hit_pul;
    logic [PPC_NPORT-1:0] hit_drv;
    logic [PPC_NPORT-1:0] hit_fst;
    logic                 addr_hit;
    logic [7:0]           read_byte;
    logic                 wr_en;
    logic                 rd_err;
    ppc_phase_t           phase;
    ppc_phase_t           next_phase;

    // derived per-pin pad controls before registering
    logic [PPC_NALL-1:0]  next_output_en;
    logic [PPC_NALL-1:0]  next_pull_up;
    logic [PPC_NOD-1:0]   next_open_drain;
    logic [PPC_NALL-1:0]  next_drive_high;
    logic [PPC_NALL-1:0]  next_drive_fast;

    // byte address of a printed index
    function automatic logic [31:0] ppc_byte_addr(input logic [31:0] idx);
        ppc_byte_addr = idx << PPC_IDX_SHIFT;
    endfunction

    // writable bits of the upper output type byte: even bits of pins that exist
    function automatic logic [7:0] ppc_otu_mask(input logic [7:0] exists);
        logic [7:0] m;
        m = 8'h00;
        for (int k = 0; k < 4; k++) begin
            m[2*k] = exists[PPC_UPPER_PIN + k];
        end
        ppc_otu_mask = m & PPC_OTU_EVEN;
    endfunction

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < PPC_NPORT; p++) begin
            hit_otu[p] = (paddr == ppc_byte_addr(PPC_OTU_IDX[p]));
            hit_pul[p] = (paddr == ppc_byte_addr(PPC_PUL_IDX[p]));
            hit_drv[p] = PPC_DRV_PRESENT[p] && (paddr == ppc_byte_addr(PPC_DRV_IDX[p]));
            hit_fst[p] = PPC_FST_PRESENT[p] && (paddr == ppc_byte_addr(PPC_FST_IDX[p]));
        end
        addr_hit = |{hit_otu, hit_pul, hit_drv, hit_fst};
    end

    // read multiplexer; reserved and absent bits are never stored, so read zero
    always_comb begin
        read_byte = 8'h00;
        for (int p = 0; p < PPC_NPORT; p++) begin
            if (hit_otu[p]) begin
                read_byte = upper_output_type_select[p];
            end
            if (hit_pul[p]) begin
                read_byte = pull_up_control[p];
            end
            if (hit_drv[p]) begin
                read_byte = drive_strength_select[p];
            end
            if (hit_fst[p]) begin
                read_byte = high_speed_drive_override[p];
            end
        end
    end

    // ------------------------------------------------------------------
    // APB slave: zero wait states, error on unmapped address
    // ------------------------------------------------------------------
    always_comb begin
        unique case (phase)
            PPC_PH_IDLE: begin
                next_phase = (psel && !penable) ? PPC_PH_SETUP : PPC_PH_IDLE;
            end
            PPC_PH_SETUP: begin
                next_phase = PPC_PH_ACCESS;
            end
            PPC_PH_ACCESS: begin
                next_phase = (psel && !penable) ? PPC_PH_SETUP : PPC_PH_IDLE;
            end
            default: begin
                next_phase = PPC_PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= PPC_PH_IDLE;
        end else if (pce) begin
            phase <= next_phase;
        end
    end

    // read data and error are captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            rd_err <= 1'b0;
        end else if (pce && psel && !penable) begin
            prdata <= pwrite ? 32'h00000000 : {24'h000000, read_byte};
            rd_err <= !addr_hit;
        end
    end

    assign pready  = psel && penable;
    assign pslverr = psel && penable && rd_err;
    // only byte lane 0 carries register data
    assign wr_en   = pce && psel && penable && pwrite && addr_hit && pstrb[0];

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < PPC_NPORT; p++) begin
                upper_output_type_select[p]  <= PPC_REG_RESET;
                pull_up_control[p]           <= PPC_REG_RESET;
                drive_strength_select[p]     <= PPC_REG_RESET;
                high_speed_drive_override[p] <= PPC_REG_RESET;
            end
        end else if (wr_en) begin
            for (int p = 0; p < PPC_NPORT; p++) begin
                if (hit_otu[p]) begin
                    // odd bits and absent pins are dropped
                    upper_output_type_select[p] <= pwdata[7:0]
                        & ppc_otu_mask(PPC_PIN_EXISTS[p]);
                end
                if (hit_pul[p]) begin
                    pull_up_control[p] <= pwdata[7:0] & PPC_PIN_EXISTS[p];
                end
                if (hit_drv[p]) begin
                    // kept for fixed-drive pins too
                    drive_strength_select[p] <= pwdata[7:0] & PPC_PIN_EXISTS[p];
                end
                if (hit_fst[p]) begin
                    high_speed_drive_override[p] <= pwdata[7:0] & PPC_PIN_EXISTS[p];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // pad control derivation
    // ------------------------------------------------------------------
    always_comb begin
        logic out_gen;
        logic out_per;
        logic is_out;
        logic fast;
        int   n;
        out_gen = 1'b0;
        out_per = 1'b0;
        is_out  = 1'b0;
        fast    = 1'b0;
        n       = 0;
        next_output_en  = '0;
        next_pull_up    = '0;
        next_open_drain = '0;
        next_drive_high = '0;
        next_drive_fast = '0;
        for (int p = 0; p < PPC_NPORT; p++) begin
            for (int b = 0; b < PPC_NPIN; b++) begin
                n = p * PPC_NPIN + b;
                out_gen = direction_select[n] && !pin_function_mode[n];
                out_per = pin_function_mode[n] && periph_output_en[n];
                is_out  = PPC_PIN_EXISTS[p][b] && (out_gen || out_per);
                next_output_en[n] = is_out;
                next_pull_up[n]   = pull_up_control[p][b] && !is_out;
                fast = PPC_FST_SWITCH[p][b] && high_speed_drive_override[p][b];
                next_drive_fast[n] = fast;
                next_drive_high[n] = fast || PPC_FIXED_HIGH[p][b]
                    || (PPC_DRV_SWITCH[p][b] && drive_strength_select[p][b]);
            end
            for (int k = 0; k < 4; k++) begin
                next_open_drain[p*4 + k] = upper_output_type_select[p][2*k];
            end
        end
    end

    // pad controls are registered; reset clears them, pull-ups included
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_output_en <= '0;
            pull_up_en    <= '0;
            open_drain_en <= '0;
            drive_high    <= '0;
            drive_fast    <= '0;
        end else if (pce) begin
            pad_output_en <= next_output_en;
            pull_up_en    <= next_pull_up;
            open_drain_en <= next_open_drain;
            drive_high    <= next_drive_high;
            drive_fast    <= next_drive_fast;
        end
    end

endmodule

// file: bench/ppc_monitor.sv
/* ppc_monitor: port-level assertions for the pad control block.
   Assumes it is bound into ppc_port_pad_control and sees its ports only. */
`timescale 1ns/1ps
module ppc_monitor
    import ppc_pkg::*;
(
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                pce,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic [31:0]         paddr,
    input wire logic                pslverr,
    input wire logic [PPC_NALL-1:0] direction_select,
    input wire logic [PPC_NALL-1:0] pin_function_mode,
    input wire logic [PPC_NALL-1:0] pad_output_en,
    input wire logic [PPC_NALL-1:0] pull_up_en,
    input wire logic [PPC_NOD-1:0]  open_drain_en,
    input wire logic [PPC_NALL-1:0] drive_high,
    input wire logic [PPC_NALL-1:0] drive_fast
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_bad_setup;
        psel && !penable && paddr[1:0] != 2'h0;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    AST_PULL_OFF_AT_RELEASE: assert property ($rose(presetn) |-> pull_up_en == '0)
        else $error("pull-up on at reset release");
    AST_INPUT_AT_RELEASE: assert property ($rose(presetn) |-> pad_output_en == '0)
        else $error("pin output at reset release");
    AST_ZERO_AT_RELEASE: assert property ($rose(presetn) |->
        open_drain_en == '0 && drive_fast == '0)
        else $error("pad control not cleared by reset");
    AST_PULL_NOT_OUTPUT: assert property ((pull_up_en & pad_output_en) == '0)
        else $error("pull-up on an output pin");
    AST_FAST_IS_HIGH: assert property ((drive_fast & ~drive_high) == '0)
        else $error("fast drive without high drive");
    AST_OUTPUT_CAUSE: assert property ($past(pce) |->
        (pad_output_en & ~($past(direction_select) | $past(pin_function_mode))) == '0)
        else $error("output without direction or mode");
    AST_PULL_INPUT_ONLY: assert property ($past(pce) |->
        (pull_up_en & $past(direction_select) & ~$past(pin_function_mode)) == '0)
        else $error("pull-up on general output pin");
    AST_UNALIGNED_ERR: assert property (s_bad_setup ##1 s_access |-> pslverr)
        else $error("unaligned access not refused");
endmodule
bind ppc_port_pad_control ppc_monitor ppc_monitor_i (.*);

// file: bench/ppc_pad_model.sv
/* ppc_pad_model: pads and board pins behind the pad controls.
   Assumes pad controls come from ppc_port_pad_control on pclk. */
`timescale 1ns/1ps
module ppc_pad_model
    import ppc_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic [PPC_NALL-1:0] pull_up_en,
    output logic      [PPC_NALL-1:0] pin_level
);
    logic [PPC_NALL-1:0] float_v = '0;
    // undriven pins toggle on every rising pclk edge, so a stale level does not last from one pad check to the next
    always @(posedge pclk) float_v <= ~float_v;
    assign pin_level = pull_up_en | float_v;
endmodule

// file: bench/tb.sv
/* tb: self-checking bench for ppc_port_pad_control.
   Assumes a zero-wait APB slave and pad outputs one edge behind. */
`timescale 1ns/1ps
module tb;
    import ppc_pkg::*;
    logic                pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0]         paddr = '0, pwdata = '0, prdata, rd;
    logic                pready, pslverr, er;
    logic [PPC_NALL-1:0] dir = '0, mode = '0, poe = '0, pad_oe, pu, dh, df, lvl;
    logic [PPC_NALL-1:0] e_oe, e_pu, e_dh, e_df, rnd_d, rnd_m;
    logic                ce = 1;
    logic [3:0]          strb = 4'hf;
    logic [PPC_NOD-1:0]  od, e_od;
    int                  bad_count = 0, samples_checked = 0, seed_v;
    int                  mdl [4][PPC_NPORT] = '{default: 0};
    always #50 pclk = ~pclk;
    ppc_port_pad_control ppc_port_pad_control_i (.pclk(pclk), .presetn(presetn), .pce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .direction_select(dir), .pin_function_mode(mode), .periph_output_en(poe),
        .pad_output_en(pad_oe), .pull_up_en(pu), .open_drain_en(od), .drive_high(dh),
        .drive_fast(df));
    ppc_pad_model ppc_pad_model_i (.pclk(pclk), .pull_up_en(pu), .pin_level(lvl));
    task automatic check(input logic [PPC_NALL-1:0] seen, input logic [PPC_NALL-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic [31:0] addr_of(int k, int p);
        logic [31:0] idx;
        case (k)
            0: idx = PPC_OTU_IDX[p];
            1: idx = PPC_PUL_IDX[p];
            2: idx = PPC_DRV_IDX[p];
            default: idx = PPC_FST_IDX[p];
        endcase
        return idx << PPC_IDX_SHIFT;
    endfunction
    // bits that hold a value: existing pins, upper type on even bits only
    function automatic logic [7:0] keep(int k, int p);
        logic [7:0] m;
        m = PPC_PIN_EXISTS[p];
        if (k == 0) m = {1'b0, m[7], 1'b0, m[6], 1'b0, m[5], 1'b0, m[4]};
        return m;
    endfunction
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20) bad_count++;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic regs_rw(input bit wr);
        logic [7:0] v;
        for (int p = 0; p < PPC_NPORT; p++) for (int k = 0; k < 4; k++) begin
            if (addr_of(k, p) == 0) continue;
            v = 8'($urandom);
            if (wr) begin
                apb(1, addr_of(k, p), {24'h0, v});
                mdl[k][p] = v & keep(k, p);
            end
            apb(0, addr_of(k, p), 0);
            check(rd, mdl[k][p]);
        end
    endtask
    task automatic pads;
        for (int p = 0; p < PPC_NPORT; p++) for (int i = 0; i < 8; i++) begin
            int b;
            b = p * 8 + i;
            e_oe[b] = PPC_PIN_EXISTS[p][i] & (mode[b] ? poe[b] : dir[b]);
            e_pu[b] = mdl[1][p][i] & ~e_oe[b];
            e_df[b] = mdl[3][p][i] & PPC_FST_SWITCH[p][i];
            e_dh[b] = PPC_FIXED_HIGH[p][i] | (mdl[2][p][i] & PPC_DRV_SWITCH[p][i]) | e_df[b];
            if (i > 3) e_od[p * 4 + i - 4] = mdl[0][p][2 * (i - 4)];
        end
        check(pad_oe, e_oe);
        check(pu, e_pu);
        check(od, e_od);
        check(dh, e_dh);
        check(df, e_df);
        check(lvl & e_pu, e_pu);
    endtask
    initial begin
        #(20000 * 100);
        bad_count++;
        end_sim;
    end
    initial begin
        seed_v = $urandom(49);
        repeat (8) @(posedge pclk);
        presetn <= 1;
        regs_rw(0);
        $display("reset values test done");
        repeat (4) begin
            regs_rw(1);
            rnd_d = 88'({$urandom, $urandom, $urandom});
            rnd_m = 88'({$urandom, $urandom, $urandom});
            for (int b = 0; b < PPC_NALL; b++) begin
                if (!PPC_PIN_EXISTS[b / 8][b % 8]) begin
                    rnd_d[b] = 1'b1;
                    rnd_m[b] = 1'b0;
                end
            end
            rnd_d[21] = 1'b0;
            dir <= rnd_d;
            mode <= rnd_m;
            poe <= 88'({$urandom, $urandom, $urandom});
            repeat (3) @(posedge pclk);
            pads;
        end
        $display("register and pad test done");
        apb(0, 32'h0000_0004, 0);
        check(er, 1);
        check(rd, 0);
        apb(1, addr_of(1, 7) | 32'h2, 32'hff);
        check(er, 1);
        apb(0, addr_of(1, 7), 0);
        check(rd, mdl[1][7]);
        ce <= 0;
        apb(1, addr_of(1, 7), {24'h0, ~8'(mdl[1][7])});
        ce <= 1;
        apb(0, addr_of(1, 7), 0);
        check(rd, mdl[1][7]);
        strb <= 4'he;
        apb(1, addr_of(1, 7), {24'h0, ~8'(mdl[1][7])});
        strb <= 4'hf;
        apb(0, addr_of(1, 7), 0);
        check(rd, mdl[1][7]);
        $display("refused access test done");
        presetn <= 0;
        @(posedge pclk);
        check(pu, 0);
        check(pad_oe, 0);
        repeat (2) @(posedge pclk);
        presetn <= 1;
        mdl = '{default: 0};
        regs_rw(0);
        $display("mid-run reset test done");
        end_sim;
    end
endmodule
